// [host_pins_regs.svh]
// Purpose: Shared constants for the display host pin front end.
// Assumes: Included by both ends; the package does not include it.
// Notes: Strap codes select the host interface style.
`ifndef HOST_PINS_REGS_SVH
`define HOST_PINS_REGS_SVH
`define MODE_SPI4 3'b000
`define MODE_SPI3 3'b001
`define MODE_TWI 3'b010
`define MODE_PAR_SEP 3'b110
`define MODE_PAR_EN 3'b100
`define TWI_ADDR_HI 6'h3_C
`define FRAME_PERIOD 16'h0_800
`define READ_HOLD 8'h0_8
`define HOST_DIV 4'h4
`endif

// [host_pins_pkg.sv]
// Purpose: Types shared with the properties checker; neither end imports them.
// Assumes: Nothing beyond the constants header.
// Notes: Mode type mirrors the strap codes.
package host_pins_pkg;
  typedef enum logic [1:0] {DEST_CMD, DEST_RAM} dest_t;
  typedef enum logic [2:0] {
    BUS_SPI4 = 3'b000,
    BUS_SPI3 = 3'b001,
    BUS_TWI = 3'b010,
    BUS_PAR_EN = 3'b100,
    BUS_PAR_SEP = 3'b110
  } bus_mode_t;
endpackage : host_pins_pkg

// [host_pins_if.sv]
// Purpose: Pin bundle between host and display device.
// Assumes: Data pins resolved from both output enables.
// Notes: Open-drain two-wire line resolved by the bench.
`timescale 1ns/10ps
interface host_pins_if;
  logic cs_n;
  logic dc_sel;
  logic rw_wr_n;
  logic en_rd_n;
  logic hw_init_n;
  logic [7:0] dev_d_o;
  logic [7:0] dev_d_oe;
  logic [7:0] host_d_o;
  logic [7:0] host_d_oe;
  logic [7:0] d_in;
  logic frame_sync_out;
  modport device (
    input cs_n, dc_sel, rw_wr_n, en_rd_n, hw_init_n, d_in,
    output dev_d_o, dev_d_oe, frame_sync_out
  );
  modport host (
    output cs_n, dc_sel, rw_wr_n, en_rd_n, hw_init_n, host_d_o, host_d_oe,
    input d_in, frame_sync_out
  );
endinterface : host_pins_if

// [host_pins_dev.sv]
// Purpose: Device end: decodes host pins into command and RAM writes.
// Assumes: All pins asynchronous to clock; two-stage synchronised.
// Notes: Two-wire mode handles address and write bytes only.
`timescale 1ns/10ps
`include "host_pins_regs.svh"
module host_pins_dev (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Strap and clock select pins
  input wire logic [2:0] bus_mode_strap,
  input wire logic int_osc_sel,
  input wire logic ext_clk_in,
  // Host pins
  host_pins_if.device pins,
  // User side
  output logic wr_valid,
  output logic [7:0] wr_byte,
  output logic wr_is_ram,
  output logic rd_req,
  output logic rd_is_ram,
  input wire logic [7:0] rd_byte,
  output logic clk_src_ext,
  output logic core_tick
);
  // ==========================================================
  // Synchronisers
  // ==========================================================
  localparam int NS = 14;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  logic [NS-1:0] s3_r;
  assign raw = {pins.cs_n, pins.dc_sel, pins.rw_wr_n, pins.en_rd_n,
                pins.hw_init_n, ext_clk_in, pins.d_in};
  always_ff @(posedge clock) begin
    s1_r <= raw;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end
  logic cs_n, dc, rw, en, init_n, eclk;
  logic [7:0] d;
  assign {cs_n, dc, rw, en, init_n, eclk, d} = s2_r;
  logic srst;
  assign srst = rst | ~init_n;

  function automatic logic rose(input logic now, input logic was);
    return now & ~was;
  endfunction : rose

  // ==========================================================
  // Mode straps and clock source
  // ==========================================================
  // Strap and clock select pins are asynchronous too, so they get two
  // stages before the mode and clock source registers read them.
  logic [3:0] strap_s1_r;
  logic [3:0] strap_s2_r;
  always_ff @(posedge clock) begin
    strap_s1_r <= {bus_mode_strap, int_osc_sel};
    strap_s2_r <= strap_s1_r;
  end
  logic [2:0] mode_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      mode_r <= strap_s2_r[3:1];
    end
  end
  logic osc_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      osc_r <= 1'b1;
    end else begin
      osc_r <= strap_s2_r[0];
    end
  end
  assign clk_src_ext = ~osc_r;
  // Internal oscillator is the system clock; external uses pin edges.
  assign core_tick = osc_r ? 1'b1 : rose(eclk, s3_r[8]);

  // ==========================================================
  // Parallel strobes
  // ==========================================================
  logic sel;
  assign sel = ~cs_n;
  logic wr_old, en_old, rd_old;
  assign wr_old = s3_r[11];
  assign en_old = s3_r[10];
  assign rd_old = s3_r[10];
  logic par_wr, par_rd_start, par_en_start;
  // Write latches at the strobe's rising edge, the end of the access.
  assign par_wr = (mode_r == `MODE_PAR_SEP) && sel
                  && rose(rw, wr_old);
  assign par_rd_start = (mode_r == `MODE_PAR_SEP) && sel
                        && rose(rd_old, en);
  assign par_en_start = (mode_r == `MODE_PAR_EN) && sel
                        && rose(en, en_old);
  logic en_fall;
  assign en_fall = (mode_r == `MODE_PAR_EN) && sel && rose(en_old, en);

  // ==========================================================
  // Serial shifter
  // ==========================================================
  logic sclk_rise;
  assign sclk_rise = sel || mode_r == `MODE_TWI ?
                     rose(d[0], s3_r[0]) : 1'b0;
  logic [8:0] sh_r;
  logic [3:0] cnt_r;
  logic ser_wr;
  logic [7:0] ser_byte;
  logic ser_ram;
  logic [3:0] need;
  assign need = (mode_r == `MODE_SPI3) ? 4'h9 : 4'h8;
  logic twi_start, twi_stop, twi_ack_r, twi_addr_r, twi_me_r;
  assign twi_start = (mode_r == `MODE_TWI) && d[0] && rose(s3_r[1], d[1]);
  assign twi_stop = (mode_r == `MODE_TWI) && d[0] && rose(d[1], s3_r[1]);
  always_ff @(posedge clock) begin
    if (srst || (cs_n && mode_r != `MODE_TWI) || twi_start || twi_stop) begin
      cnt_r <= 4'h0;
      sh_r <= 9'h0_00;
    end else if (sclk_rise) begin
      sh_r <= {sh_r[7:0], d[1]};
      cnt_r <= (cnt_r + 4'h1 >= need) || twi_ack_r ? 4'h0 : cnt_r + 4'h1;
    end
  end
  logic ser_full;
  assign ser_full = sclk_rise && !twi_ack_r && (cnt_r + 4'h1 == need);
  assign ser_byte = {sh_r[6:0], d[1]};
  always_comb begin
    ser_wr = 1'b0;
    ser_ram = 1'b0;
    case (mode_r)
      `MODE_SPI4: begin
        ser_wr = ser_full;
        ser_ram = dc;
      end
      `MODE_SPI3: begin
        ser_wr = ser_full;
        ser_ram = sh_r[7];
      end
      `MODE_TWI: begin
        ser_wr = ser_full && twi_me_r && !twi_addr_r;
        ser_ram = 1'b0;
      end
      default: begin
        ser_wr = 1'b0;
      end
    endcase
  end
  // Two-wire: first byte is address; an acknowledge slot follows each byte once the address matches.
  always_ff @(posedge clock) begin
    if (srst || twi_start) begin
      twi_addr_r <= 1'b1;
      twi_me_r <= 1'b0;
      twi_ack_r <= 1'b0;
    end else if (ser_full && mode_r == `MODE_TWI) begin
      if (twi_addr_r) begin
        twi_me_r <= ser_byte[7:1] == {`TWI_ADDR_HI, dc};
      end
      twi_addr_r <= 1'b0;
      twi_ack_r <= twi_addr_r ? (ser_byte[7:1] == {`TWI_ADDR_HI, dc})
                              : twi_me_r;
    end else if (sclk_rise) begin
      twi_ack_r <= 1'b0;
    end
  end

  // ==========================================================
  // Write output and read drive
  // ==========================================================
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_valid <= 1'b0;
      wr_byte <= 8'h0_0;
      wr_is_ram <= 1'b0;
    end else begin
      wr_valid <= par_wr || (en_fall && !rw) || ser_wr;
      wr_byte <= ser_wr ? ser_byte : d;
      wr_is_ram <= ser_wr ? ser_ram : dc;
    end
  end
  logic drive_r;
  logic [7:0] dout_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_req <= 1'b0;
      rd_is_ram <= 1'b0;
    end else begin
      rd_req <= par_rd_start || (par_en_start && rw);
      rd_is_ram <= dc;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      drive_r <= 1'b0;
      dout_r <= 8'h0_0;
    end else begin
      if (rd_req) begin
        drive_r <= 1'b1;
        dout_r <= rd_byte;
      end else if (cs_n || (mode_r == `MODE_PAR_SEP && en)
                   || (mode_r == `MODE_PAR_EN && !en)) begin
        drive_r <= 1'b0;
      end
    end
  end
  // Two-wire acknowledge pulls pin 2 low; parallel reads drive all pins.
  assign pins.dev_d_o = (mode_r == `MODE_TWI) ? 8'h0_0 : dout_r;
  assign pins.dev_d_oe = (mode_r == `MODE_TWI) ? {5'h0_0, twi_ack_r, 2'h0}
                         : {8{drive_r}};

  // ==========================================================
  // Frame sync
  // ==========================================================
  logic [15:0] fcnt_r;
  logic fs_r;
  always_ff @(posedge clock) begin
    if (srst) begin
      fcnt_r <= 16'h0_000;
      fs_r <= 1'b0;
    end else if (core_tick) begin
      fcnt_r <= (fcnt_r == `FRAME_PERIOD - 16'h0_001) ? 16'h0_000
                : fcnt_r + 16'h0_001;
      fs_r <= fcnt_r < (`FRAME_PERIOD >> 1);
    end
  end
  assign pins.frame_sync_out = fs_r;
endmodule : host_pins_dev

// [host_pins_host.sv]
// Purpose: Host end: drives parallel or serial writes and parallel reads.
// Assumes: Same strap mode as the device; two-wire not issued by host.
// Notes: Serial clock made by dividing the host clock.
`timescale 1ns/10ps
`include "host_pins_regs.svh"
module host_pins_host (
  // Clock, reset and bus mode
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] mode,
  // Request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic req_ram,
  input wire logic [7:0] req_byte,
  // Answer
  output logic rsp_valid,
  output logic [7:0] rsp_byte,
  // Pins
  host_pins_if.host pins
);
  typedef enum {IDLE, SETUP, STROBE, HOLD, SHIFT} st_t;
  st_t st_r;
  logic [7:0] cnt_r;
  logic [3:0] bit_r;
  logic [8:0] sh_r;
  logic rd_r, ram_r, sclk_r;
  logic [7:0] s1_r, s2_r;
  always_ff @(posedge clock) begin
    s1_r <= pins.d_in;
    s2_r <= s1_r;
  end
  logic serial;
  assign serial = mode == `MODE_SPI4 || mode == `MODE_SPI3;
  assign req_ready = st_r == IDLE;
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= IDLE;
      cnt_r <= 8'h0_0;
      bit_r <= 4'h0;
      sh_r <= 9'h0_00;
      rd_r <= 1'b0;
      ram_r <= 1'b0;
      sclk_r <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_byte <= 8'h0_0;
    end else begin
      rsp_valid <= 1'b0;
      cnt_r <= cnt_r + 8'h0_1;
      case (st_r)
        IDLE: begin
          if (req_valid) begin
            rd_r <= req_read && !serial;
            ram_r <= req_ram;
            sh_r <= {req_ram, req_byte};
            bit_r <= (mode == `MODE_SPI3) ? 4'h9 : 4'h8;
            cnt_r <= 8'h0_0;
            st_r <= serial ? SHIFT : SETUP;
          end
        end
        SETUP: if (cnt_r == `READ_HOLD) begin
          cnt_r <= 8'h0_0;
          st_r <= STROBE;
        end
        STROBE: if (cnt_r == `READ_HOLD) begin
          if (rd_r) begin
            rsp_byte <= s2_r;
            rsp_valid <= 1'b1;
          end
          cnt_r <= 8'h0_0;
          st_r <= HOLD;
        end
        HOLD: if (cnt_r == `READ_HOLD) begin
          st_r <= IDLE;
        end
        SHIFT: if (cnt_r[3:0] == `HOST_DIV) begin
          cnt_r <= 8'h0_0;
          sclk_r <= ~sclk_r;
          if (sclk_r) begin
            sh_r <= {sh_r[7:0], 1'b0};
            bit_r <= bit_r - 4'h1;
            if (bit_r == 4'h1) begin
              st_r <= HOLD;
            end
          end
        end
        default: st_r <= IDLE;
      endcase
    end
  end
  logic act;
  assign act = st_r != IDLE;
  logic strobe;
  assign strobe = st_r == STROBE;
  always_comb begin
    pins.hw_init_n = ~rst;
    pins.cs_n = ~act;
    pins.dc_sel = (mode == `MODE_SPI3) ? 1'b0 : ram_r;
    pins.rw_wr_n = 1'b0;
    pins.en_rd_n = 1'b0;
    pins.host_d_o = 8'h0_0;
    pins.host_d_oe = 8'hF_F;
    case (mode)
      `MODE_PAR_SEP: begin
        pins.rw_wr_n = ~(strobe && !rd_r);
        pins.en_rd_n = ~(strobe && rd_r);
        pins.host_d_o = sh_r[7:0];
        pins.host_d_oe = {8{!rd_r}};
      end
      `MODE_PAR_EN: begin
        pins.rw_wr_n = rd_r;
        pins.en_rd_n = strobe;
        pins.host_d_o = sh_r[7:0];
        pins.host_d_oe = {8{!rd_r}};
      end
      default: begin
        pins.host_d_o = {6'h0_0, (mode == `MODE_SPI3) ? sh_r[8] : sh_r[7],
                         sclk_r};
      end
    endcase
  end
endmodule : host_pins_host

// [host_pins_properties.sv]
// Purpose: Wire-level properties of the host pin bundle.
// Assumes: Both ends share one strap setting per reset.
// Notes: Drive bounds allow for the two-stage pin synchroniser.
`timescale 1ns/10ps
module host_pins_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Straps and pins
  input wire logic [2:0] bus_mode_strap,
  input wire logic cs_n,
  input wire logic dc_sel,
  input wire logic rw_wr_n,
  input wire logic en_rd_n,
  input wire logic [7:0] dev_d_oe,
  input wire logic [7:0] host_d_oe,
  input wire logic frame_sync_out
);
  localparam int FRAME_LIMIT = 25000;
  logic sep_m;
  logic en_m;
  logic ser_m;
  logic fs_r;
  logic [15:0] quiet_r;
  assign sep_m = bus_mode_strap == host_pins_pkg::BUS_PAR_SEP;
  assign en_m = bus_mode_strap == host_pins_pkg::BUS_PAR_EN;
  assign ser_m = bus_mode_strap[2:1] == 2'b00;
  // The limit is wide because an external clock slows the refresh ticks.
  always_ff @(posedge clock) begin
    fs_r <= frame_sync_out;
    if (rst || fs_r != frame_sync_out) begin
      quiet_r <= 16'h0000;
    end else begin
      quiet_r <= quiet_r + 16'h0001;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_deselect_quiet: assert property (cs_n [*5] |-> dev_d_oe == 8'h00)
    else $error("device drives while deselected");
  a_serial_no_read: assert property (ser_m |-> dev_d_oe == 8'h00)
    else $error("device drives in serial mode");
  a_sep_read_drive: assert property
    ((sep_m && !cs_n && !en_rd_n) [*8] |-> dev_d_oe == 8'hff)
    else $error("read strobe did not get data");
  a_en_read_drive: assert property
    ((en_m && !cs_n && rw_wr_n && en_rd_n) [*8] |-> dev_d_oe == 8'hff)
    else $error("enable read did not get data");
  a_en_write_quiet: assert property
    ((en_m && !rw_wr_n) [*5] |-> dev_d_oe == 8'h00)
    else $error("device drives in write cycle");
  a_no_bus_fight: assert property ((dev_d_oe & host_d_oe) == 8'h00)
    else $error("both ends drive the data bus");
  a_sep_strobe_cs: assert property (sep_m && !rw_wr_n |-> !cs_n)
    else $error("write strobe without chip select");
  a_en_strobe_cs: assert property (en_m && en_rd_n |-> !cs_n)
    else $error("enable strobe without chip select");
  a_spi3_dc_low: assert property
    (bus_mode_strap == host_pins_pkg::BUS_SPI3 |-> !dc_sel)
    else $error("select not grounded in three-wire mode");
  a_frame_alive: assert property (quiet_r < FRAME_LIMIT)
    else $error("frame sync stopped");
  c_sep_write: cover property (sep_m && !rw_wr_n && !cs_n);
  c_en_read: cover property (en_m && dev_d_oe == 8'hff);
  c_frame: cover property (fs_r != frame_sync_out);
endmodule : host_pins_properties

// [tb_multi_mode_host_pin_front_end.sv]
// Purpose: Runs writes through both ends in four bus modes (not two-wire), reads in the two parallel ones.
// Assumes: Host and device straps are kept equal.
// Notes: Undriven data pins read low, as unused pins are tied low.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_multi_mode_host_pin_front_end;
  localparam logic [2:0] mode_list [4] = '{3'b110, 3'b100, 3'b000, 3'b001};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [2:0] strap = 3'b110;
  logic int_osc_sel = 1'b1;
  logic ext_clk_in = 1'b0;
  logic req_valid = 1'b0;
  logic req_read = 1'b0;
  logic req_ram = 1'b0;
  logic [7:0] req_byte = 8'h00;
  logic [7:0] rd_byte = 8'h00;
  logic wr_valid, wr_is_ram, rd_req, rd_is_ram, clk_src_ext, core_tick;
  logic req_ready, rsp_valid;
  logic [7:0] wr_byte, rsp_byte;
  logic [9:0] exp_q [$];
  logic [9:0] e;
  int n_fail = 0;
  int tests_run = 0;
  int fs_edges = 0;
  int n0 = 0;
  logic fs_seen = 1'b0;
  host_pins_if pins_bus ();
  always #2.5 clock = ~clock;
  always #24 ext_clk_in = ~ext_clk_in;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pins_bus.d_in[i] = pins_bus.dev_d_oe[i] ? pins_bus.dev_d_o[i] :
        pins_bus.host_d_oe[i] ? pins_bus.host_d_o[i] : 1'b0;
    end
  end
  host_pins_dev host_pins_dev_i (.clock(clock), .rst(rst),
    .bus_mode_strap(strap), .int_osc_sel(int_osc_sel),
    .ext_clk_in(ext_clk_in), .pins(pins_bus.device), .wr_valid(wr_valid),
    .wr_byte(wr_byte), .wr_is_ram(wr_is_ram), .rd_req(rd_req),
    .rd_is_ram(rd_is_ram), .rd_byte(rd_byte), .clk_src_ext(clk_src_ext),
    .core_tick(core_tick));
  host_pins_host host_pins_host_i (.clock(clock), .rst(rst), .mode(strap),
    .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read),
    .req_ram(req_ram), .req_byte(req_byte), .rsp_valid(rsp_valid),
    .rsp_byte(rsp_byte), .pins(pins_bus.host));
  host_pins_properties host_pins_properties_i (.clock(clock), .rst(rst),
    .bus_mode_strap(strap), .cs_n(pins_bus.cs_n), .dc_sel(pins_bus.dc_sel),
    .rw_wr_n(pins_bus.rw_wr_n), .en_rd_n(pins_bus.en_rd_n),
    .dev_d_oe(pins_bus.dev_d_oe), .host_d_oe(pins_bus.host_d_oe),
    .frame_sync_out(pins_bus.frame_sync_out));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // Waits for the answer so that results never overlap in the queue.
  task automatic do_req(input logic rd, input logic ram, input logic [7:0] b);
    int n;
    exp_q.push_back({rd, ram, b});
    @(posedge clock);
    req_valid <= 1'b1;
    req_read <= rd;
    req_ram <= ram;
    req_byte <= b;
    rd_byte <= b;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 2000);
    @(posedge clock);
    req_valid <= 1'b0;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    `CHK("pending", 0, exp_q.size())
    exp_q.delete();
  endtask : do_req
  always @(negedge clock) begin
    if (pins_bus.frame_sync_out !== fs_seen) begin
      fs_edges++;
    end
    fs_seen = pins_bus.frame_sync_out;
  end
  always @(negedge clock) begin
    if (wr_valid === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 10'h3ff;
      `CHK("write", e, {1'b0, wr_is_ram, wr_byte})
    end
    if (rd_req === 1'b1) begin
      e = exp_q.size() ? exp_q[0] : 10'h3ff;
      `CHK("read_dest", e[8], rd_is_ram)
    end
    if (rsp_valid === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 10'h3ff;
      `CHK("read", e, {2'b10, rsp_byte} | {1'b0, e[8], 8'h00})
    end
  end
  initial begin
    void'($urandom(10420));
    foreach (mode_list[m]) begin
      @(posedge clock);
      rst <= 1'b1;
      strap <= mode_list[m];
      int_osc_sel <= ~m[0];
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      `CHK("clk_src", ~int_osc_sel, clk_src_ext)
      // Reads only exist in the parallel styles; serial is write only.
      for (int k = 0; k < 6; k++) begin
        do_req(mode_list[m][2] & k[0], 1'($urandom), 8'($urandom));
      end
      if (m == 0) begin
        n0 = fs_edges;
        repeat (2600) @(posedge clock);
        `CHK("frame_sync", 1'b1, fs_edges - n0 >= 2)
        `CHK("core_tick", 1'b1, core_tick)
      end
    end
    give_verdict();
  end
  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    give_verdict();
  end
endmodule : tb_multi_mode_host_pin_front_end
